// ==== usb_cmd_pkg.sv ====
// constants shared by the command port device end and its host end
// Overview of operation
// - new setup before ack or stall sets overrun flag
// - reading status clears overrun once setup stored
// - firmware checks overrun before ack or stall
// - status bit 2 shows setup in buffer
// - status bit 1 shows cpu buffer select
// - setup arrival disables validate and clear commands for buffers 0 and 1
// - code f4 acknowledges setup, re-enables commands
// - codes a0..af read one endpoint status byte
// - each new transaction overwrites stored status
// - bit 7 flags event before status read
// - bit 6 holds last good data toggle
// - bit 0 set on successful transfer
// - code 0001 bad pid check, 0010 unknown
// - code 0011 unexpected packet or misdirected setup
// - error field bits 4..1 with listed codes
// - code 1001 when nak sent or received
// - code 1010 when stall handshake sent
// - code 1011 when packet overflows buffer
// - codes 1100 empty iso, 1111 wrong toggle
// - suspend blocks writes and reads until unlock
// - firmware sends b0 then 37, aa
// - key aa37 lifts the protection
package usb_cmd_pkg;
	// command codes
	localparam logic [7:0]  CMD_ACK_SETUP = 8'hf4;
	localparam logic [7:0]  CMD_UNLOCK    = 8'hb0;
	localparam logic [3:0]  GRP_VALIDATE  = 4'h6;
	localparam logic [3:0]  GRP_CLEAR     = 4'h7;
	localparam logic [3:0]  GRP_ERR_READ  = 4'ha;
	localparam logic [3:0]  GRP_STAT_READ = 4'hd;
	localparam logic [15:0] UNLOCK_KEY    = 16'haa37;
	// status copy fields
	localparam int OVR_BIT   = 3;
	localparam int SETUP_BIT = 2;
	localparam int CPU_BUFFER_SELECT_BIT = 1;
	// transaction status fields
	localparam int MISSED_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERR_LSB    = 1;
	localparam int OK_BIT     = 0;
	// error codes
	localparam logic [3:0] ERR_NONE      = 4'h0;
	localparam logic [3:0] ERR_PID_CHECK = 4'h1;
	localparam logic [3:0] ERR_PID_UNDEF = 4'h2;
	localparam logic [3:0] ERR_UNEXPECT  = 4'h3;
	localparam logic [3:0] ERR_TOKEN_CRC = 4'h4;
	localparam logic [3:0] ERR_DATA_CRC  = 4'h5;
	localparam logic [3:0] ERR_TIMEOUT   = 4'h6;
	localparam logic [3:0] ERR_BABBLE    = 4'h7;
	localparam logic [3:0] ERR_EOP       = 4'h8;
	localparam logic [3:0] ERR_NAK       = 4'h9;
	localparam logic [3:0] ERR_STALL     = 4'ha;
	localparam logic [3:0] ERR_OVERFLOW  = 4'hb;
	localparam logic [3:0] ERR_ISO_EMPTY = 4'hc;
	localparam logic [3:0] ERR_STUFF     = 4'hd;
	localparam logic [3:0] ERR_SYNC      = 4'he;
	localparam logic [3:0] ERR_TOGGLE    = 4'hf;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	// host apb map
	localparam logic [11:0] ORDER_OFS  = 12'h000;
	localparam logic [11:0] REPORT_OFS = 12'h004;
	localparam int ORD_CODE_LSB  = 0;
	localparam int ORD_D0_LSB    = 8;
	localparam int ORD_D1_LSB    = 16;
	localparam int ORD_NWR_LSB   = 24;
	localparam int ORD_READ_BIT  = 26;
	localparam int REP_BUSY_BIT  = 0;
	localparam int REP_DATA_LSB  = 8;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_CMD   = 3'b001,
		H_DATA  = 3'b010,
		H_READ  = 3'b011,
		H_WAITR = 3'b100
	} host_state_e;
endpackage : usb_cmd_pkg

// ==== cmd_port_if.sv ====
// parallel command port between controller firmware and the usb device
`timescale 1ns/1ps
`default_nettype none
interface cmd_port_if;
	logic       wr;
	logic       rd;
	logic       a0;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rvalid;
	modport dev (input wr, input rd, input a0, input wdata, output rdata, output rvalid);
	modport host (output wr, output rd, output a0, output wdata, input rdata, input rvalid);
endinterface : cmd_port_if
`default_nettype wire

// ==== usb_cmd_device.sv ====
// device end: setup flags, transaction status, unlock and command decode
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_device (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// command port
	cmd_port_if.dev          port,
	// usb engine side
	input  wire logic        setup_rx,
	input  wire logic        setup_store_done,
	input  wire logic        ep0_stalled,
	input  wire logic        suspend,
	input  wire logic        txn_valid,
	input  wire logic [3:0]  txn_ep,
	input  wire logic [3:0]  txn_code,
	input  wire logic [7:0]  txn_pid,
	input  wire logic        txn_ok,
	input  wire logic        txn_toggle,
	// buffer command outputs
	output logic             validate_pulse,
	output logic             clear_pulse,
	output logic [3:0]       buf_ep,
	output logic             write_locked,
	output logic             setup_cmds_off
);
	import usb_cmd_pkg::*;

	// ==========================================================
	// pid sanity check ahead of the engine's own code
	function automatic logic [3:0] classify(input logic [7:0] pid, input logic [3:0] code);
		logic [3:0] res;
		res = code;
		if (pid[7:4] != ~pid[3:0])
			res = ERR_PID_CHECK;
		else if (pid[3:0] == 4'h0)
			res = ERR_PID_UNDEF;
		return res;
	endfunction : classify

	// ==========================================================
	// state
	logic [7:0]  cmd_q, cmd_d;
	logic        byte_q, byte_d;
	logic [7:0]  key_lo_q, key_lo_d;
	logic        locked_q, locked_d;
	logic        pending_q, pending_d;
	logic        present_q, present_d;
	logic        overrun_q, overrun_d;
	logic [15:0] cpu_buffer_select_q, cpu_buffer_select_d;
	logic [15:0] status_missed_flag_q, status_missed_flag_d;
	logic [7:0]  stat_q [16];
	logic [7:0]  stat_d [16];
	logic [7:0]  rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        valid_q, valid_d;
	logic        clr_q, clr_d;
	logic [3:0]  bep_q, bep_d;

	logic       cmd_wr;
	logic       dat_wr;
	logic       dat_rd;
	logic [3:0] sel;
	logic [3:0] grp;
	logic [7:0] image;

	assign cmd_wr = port.wr & port.a0;
	assign dat_wr = port.wr & ~port.a0;
	assign dat_rd = port.rd & ~port.a0;
	assign sel    = cmd_q[3:0];
	assign grp    = cmd_q[7:4];

	// ==========================================================
	// next state
	always_comb begin
		cmd_d     = cmd_q;
		byte_d    = byte_q;
		key_lo_d  = key_lo_q;
		locked_d  = locked_q;
		pending_d = pending_q;
		present_d = present_q;
		overrun_d = overrun_q;
		cpu_buffer_select_d  = cpu_buffer_select_q;
		status_missed_flag_d  = status_missed_flag_q;
		stat_d    = stat_q;
		rdata_d   = rdata_q;
		rvalid_d  = 1'b0;
		valid_d   = 1'b0;
		clr_d     = 1'b0;
		bep_d     = bep_q;
		image     = STATUS_RST;

		// ---- command phase
		if (cmd_wr) begin
			cmd_d  = port.wdata;
			byte_d = 1'b0;
			if (!locked_q) begin
				if (port.wdata == CMD_ACK_SETUP)
					pending_d = 1'b0;
				if ((port.wdata[7:4] == GRP_VALIDATE || port.wdata[7:4] == GRP_CLEAR)
						&& !(pending_q && port.wdata[3:1] == 3'b000)) begin
					valid_d = (port.wdata[7:4] == GRP_VALIDATE);
					clr_d   = (port.wdata[7:4] == GRP_CLEAR);
					bep_d   = port.wdata[3:0];
					cpu_buffer_select_d[port.wdata[3:0]] = ~cpu_buffer_select_q[port.wdata[3:0]];
					if (port.wdata[3:0] == 4'h0 && port.wdata[7:4] == GRP_CLEAR)
						present_d = 1'b0;
				end
			end
		end

		// ---- unlock key, low byte first
		if (dat_wr && cmd_q == CMD_UNLOCK) begin
			byte_d = ~byte_q;
			if (!byte_q)
				key_lo_d = port.wdata;
			else if ({port.wdata, key_lo_q} == UNLOCK_KEY && !suspend)
				locked_d = 1'b0;
			else
				locked_d = 1'b1;
		end

		// ---- reads
		image[OVR_BIT]    = (sel == 4'h0) ? overrun_q : 1'b0;
		image[SETUP_BIT]  = (sel == 4'h0) ? present_q : 1'b0;
		image[CPU_BUFFER_SELECT_BIT] = cpu_buffer_select_q[sel];
		if (dat_rd) begin
			rvalid_d = 1'b1;
			rdata_d  = STATUS_RST;
			if (!locked_q) begin
				if (grp == GRP_ERR_READ) begin
					rdata_d = stat_q[sel];
					status_missed_flag_d[sel] = 1'b0;
					stat_d[sel][MISSED_BIT] = 1'b0;
				end else if (grp == GRP_STAT_READ) begin
					rdata_d = image;
					if (sel == 4'h0 && setup_store_done)
						overrun_d = 1'b0;
				end
			end
		end

		// ---- usb events; set wins over clear
		if (setup_rx) begin
			if (pending_q && !ep0_stalled)
				overrun_d = 1'b1;
			pending_d = 1'b1;
			present_d = 1'b1;
		end else if (ep0_stalled) begin
			pending_d = 1'b0;
		end
		if (txn_valid) begin
			stat_d[txn_ep][MISSED_BIT] = status_missed_flag_q[txn_ep] | stat_q[txn_ep][MISSED_BIT];
			if (txn_ok)
				stat_d[txn_ep][TOGGLE_BIT] = txn_toggle;
			stat_d[txn_ep][5] = 1'b0;
			stat_d[txn_ep][ERR_LSB +: 4] = classify(txn_pid, txn_code);
			stat_d[txn_ep][OK_BIT] = txn_ok;
			status_missed_flag_d[txn_ep] = 1'b1;
		end
		if (suspend)
			locked_d = 1'b1;
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q     <= 8'h00;
			byte_q    <= 1'b0;
			key_lo_q  <= 8'h00;
			locked_q  <= 1'b0;
			pending_q <= 1'b0;
			present_q <= 1'b0;
			overrun_q <= 1'b0;
			cpu_buffer_select_q  <= 16'h0000;
			status_missed_flag_q  <= 16'h0000;
			for (int i = 0; i < 16; i++) begin
				stat_q[i] <= STATUS_RST;
			end
			rdata_q   <= 8'h00;
			rvalid_q  <= 1'b0;
			valid_q   <= 1'b0;
			clr_q     <= 1'b0;
			bep_q     <= 4'h0;
		end else begin
			cmd_q     <= cmd_d;
			byte_q    <= byte_d;
			key_lo_q  <= key_lo_d;
			locked_q  <= locked_d;
			pending_q <= pending_d;
			present_q <= present_d;
			overrun_q <= overrun_d;
			cpu_buffer_select_q  <= cpu_buffer_select_d;
			status_missed_flag_q  <= status_missed_flag_d;
			stat_q    <= stat_d;
			rdata_q   <= rdata_d;
			rvalid_q  <= rvalid_d;
			valid_q   <= valid_d;
			clr_q     <= clr_d;
			bep_q     <= bep_d;
		end
	end

	assign port.rdata     = rdata_q;
	assign port.rvalid    = rvalid_q;
	assign validate_pulse = valid_q;
	assign clear_pulse    = clr_q;
	assign buf_ep         = bep_q;
	assign write_locked   = locked_q;
	assign setup_cmds_off = pending_q;
endmodule : usb_cmd_device
`default_nettype wire

// ==== usb_cmd_host.sv ====
// host end: apb registers driving command sequences on the command port
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_host (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// command port
	cmd_port_if.host         port
);
	import usb_cmd_pkg::*;

	// ==========================================================
	host_state_e st_q, st_d;
	logic [26:0] ord_q, ord_d;
	logic [1:0]  cnt_q, cnt_d;
	logic [7:0]  rbyte_q, rbyte_d;
	logic        wr_q, wr_d, rd_q, rd_d, a0_q, a0_d;
	logic [7:0]  wd_q, wd_d;
	logic        rdy_q, rdy_d, err_q, err_d;
	logic [31:0] prd_q, prd_d;
	logic        take;
	logic        busy;

	assign busy = (st_q != H_IDLE);
	assign take = psel & penable & rdy_q;

	always_comb begin
		st_d    = st_q;
		ord_d   = ord_q;
		cnt_d   = cnt_q;
		rbyte_d = rbyte_q;
		wr_d    = 1'b0;
		rd_d    = 1'b0;
		a0_d    = a0_q;
		wd_d    = wd_q;
		rdy_d   = psel & penable & ~rdy_q;
		err_d   = 1'b0;
		prd_d   = 32'h0000_0000;
		if (psel & penable & ~rdy_q) begin
			if (paddr == REPORT_OFS && !pwrite)
				prd_d = {16'h0000, rbyte_q, 7'h00, busy};
			else if (paddr != ORDER_OFS && paddr != REPORT_OFS)
				err_d = 1'b1;
		end
		case (st_q)
			H_IDLE: begin
				if (take && pwrite && paddr == ORDER_OFS) begin
					ord_d = pwdata[26:0];
					st_d  = H_CMD;
				end
			end
			H_CMD: begin
				wr_d  = 1'b1;
				a0_d  = 1'b1;
				wd_d  = ord_q[ORD_CODE_LSB +: 8];
				cnt_d = 2'd0;
				st_d  = H_DATA;
			end
			H_DATA: begin
				a0_d = 1'b0;
				if (cnt_q < ord_q[ORD_NWR_LSB +: 2]) begin
					wr_d  = 1'b1;
					wd_d  = (cnt_q == 2'd0) ? ord_q[ORD_D0_LSB +: 8] : ord_q[ORD_D1_LSB +: 8];
					cnt_d = cnt_q + 2'd1;
				end else begin
					st_d = ord_q[ORD_READ_BIT] ? H_READ : H_IDLE;
				end
			end
			H_READ: begin
				rd_d = 1'b1;
				st_d = H_WAITR;
			end
			H_WAITR: begin
				if (port.rvalid) begin
					rbyte_d = port.rdata;
					st_d    = H_IDLE;
				end
			end
			default: st_d = H_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q    <= H_IDLE;
			ord_q   <= 27'h0;
			cnt_q   <= 2'd0;
			rbyte_q <= 8'h00;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			a0_q    <= 1'b0;
			wd_q    <= 8'h00;
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
			prd_q   <= 32'h0000_0000;
		end else begin
			st_q    <= st_d;
			ord_q   <= ord_d;
			cnt_q   <= cnt_d;
			rbyte_q <= rbyte_d;
			wr_q    <= wr_d;
			rd_q    <= rd_d;
			a0_q    <= a0_d;
			wd_q    <= wd_d;
			rdy_q   <= rdy_d;
			err_q   <= err_d;
			prd_q   <= prd_d;
		end
	end

	assign pready     = rdy_q;
	assign pslverr    = err_q;
	assign prdata     = prd_q;
	assign port.wr    = wr_q;
	assign port.rd    = rd_q;
	assign port.a0    = a0_q;
	assign port.wdata = wd_q;
endmodule : usb_cmd_host
`default_nettype wire

// ==== cmd_properties.sv ====
// concurrent checks on the command port between host and device ends
`timescale 1ns/1ps
`default_nettype none
module cmd_properties
	import usb_cmd_pkg::*;
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// command port
	input wire logic       wr,
	input wire logic       rd,
	input wire logic       a0,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       rvalid,
	// device side
	input wire logic       setup_rx,
	input wire logic       suspend,
	input wire logic       validate_pulse,
	input wire logic       clear_pulse,
	input wire logic       write_locked,
	input wire logic       setup_cmds_off
);
	// =====================================
	// sequences
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ctrl_buf;
	assign ctrl_buf = wr && a0 && (wdata[7:4] == GRP_VALIDATE || wdata[7:4] == GRP_CLEAR) && wdata[3:1] == 3'h0;
	sequence cmd_s(c);
		wr && a0 && wdata == c;
	endsequence
	sequence key_s;
		cmd_s(CMD_UNLOCK) ##1 wr && !a0 && wdata == 8'h37;
	endsequence
	// =====================================
	// properties
	AST_READ_ANSWER: assert property (rd |=> rvalid)
		else $error("no answer after read strobe");
	AST_LOCKED_READ: assert property (rd && write_locked |=> rvalid && rdata == 8'h00)
		else $error("read while locked not zero");
	AST_SUSPEND_LOCK: assert property (suspend |=> write_locked)
		else $error("suspend did not lock");
	AST_SETUP_OFF: assert property (setup_rx |=> setup_cmds_off)
		else $error("setup did not disable buffer commands");
	AST_CTRL_IGNORED: assert property (ctrl_buf && setup_cmds_off |=> !validate_pulse && !clear_pulse)
		else $error("control buffer command taken during setup");
	AST_ACK_ON: assert property (cmd_s(CMD_ACK_SETUP) ##0 !write_locked && !setup_rx |=> !setup_cmds_off)
		else $error("acknowledge did not re-enable commands");
	AST_UNLOCK: assert property (key_s ##1 wr && !a0 && wdata == 8'haa && !suspend |=> !write_locked)
		else $error("good key did not unlock");
	AST_BAD_KEY: assert property (key_s ##1 wr && !a0 && wdata != 8'haa |=> write_locked)
		else $error("wrong key unlocked");
endmodule : cmd_properties
`default_nettype wire

// ==== usb_setup_error_unlock_cmds_test.sv ====
// self-checking bench joining host and device ends of the command port
`timescale 1ns/1ps
`default_nettype none
module usb_setup_error_unlock_cmds_test;
	import usb_cmd_pkg::*;
	logic        pclk = 1'h0, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        setup_rx, store_done, suspend, txn_valid, txn_ok, txn_toggle;
	logic [3:0]  txn_ep, txn_code, ep, lo;
	logic [7:0]  txn_pid, b, s;
	logic [1:0]  r;
	logic        validate_pulse, clear_pulse, write_locked, setup_cmds_off;
	logic        stall;
	logic [3:0]  last_ep;
	logic [3:0]  buf_ep;
	logic        tog [16];
	int          fail_count, n_tests, cyc, i, n_val, n_clr;
	integer      seed = 32'hf527;
	// =====================================
	// design
	cmd_port_if i_cmd_port_if ();
	usb_cmd_host i_usb_cmd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .port(i_cmd_port_if));
	usb_cmd_device i_usb_cmd_device (.pclk(pclk), .presetn(presetn), .port(i_cmd_port_if),
		.setup_rx(setup_rx), .setup_store_done(store_done), .ep0_stalled(stall), .suspend(suspend),
		.txn_valid(txn_valid), .txn_ep(txn_ep), .txn_code(txn_code), .txn_pid(txn_pid),
		.txn_ok(txn_ok), .txn_toggle(txn_toggle), .validate_pulse(validate_pulse),
		.clear_pulse(clear_pulse), .buf_ep(buf_ep), .write_locked(write_locked),
		.setup_cmds_off(setup_cmds_off));
	cmd_properties i_cmd_properties (.pclk(pclk), .presetn(presetn), .wr(i_cmd_port_if.wr),
		.rd(i_cmd_port_if.rd), .a0(i_cmd_port_if.a0), .wdata(i_cmd_port_if.wdata),
		.rdata(i_cmd_port_if.rdata), .rvalid(i_cmd_port_if.rvalid), .setup_rx(setup_rx),
		.suspend(suspend), .validate_pulse(validate_pulse), .clear_pulse(clear_pulse),
		.write_locked(write_locked), .setup_cmds_off(setup_cmds_off));
	always #12.5 pclk = ~pclk;
	// count accepted buffer commands while their pulses stand
	always @(posedge pclk) begin
		if (validate_pulse) n_val++;
		if (clear_pulse) n_clr++;
		if (validate_pulse | clear_pulse) last_ep = buf_ep;
	end
	// =====================================
	// tasks
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task order(input logic [7:0] c, d0, d1, input logic [1:0] n, input logic rd);
		apb(1'h1, ORDER_OFS, {5'h0, rd, n, d1, d0, c});
		do apb(1'h0, REPORT_OFS, 32'h0); while (q[REP_BUSY_BIT] !== 1'h0);
		b = q[15:8];
	endtask : order
	task chk(input logic [31:0] g, x);
		n_tests++;
		if (g !== x) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task txn(input logic [3:0] p, c, input logic [7:0] pid, input logic ok, t);
		txn_valid <= 1'h1;
		txn_ep <= p;
		txn_code <= c;
		txn_pid <= pid;
		txn_ok <= ok;
		txn_toggle <= t;
		@(posedge pclk) txn_valid <= 1'h0;
		if (ok) tog[p] = t;
		@(posedge pclk);
	endtask : txn
	task setup_pkt;
		setup_rx <= 1'h1;
		@(posedge pclk) setup_rx <= 1'h0;
		@(posedge pclk);
	endtask : setup_pkt
	function automatic logic [7:0] est(input logic m, t, input logic [3:0] c, input logic ok);
		return {m, t, 1'h0, c, ok};
	endfunction : est
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end
	// =====================================
	// sequence
	initial begin
		{presetn, psel, penable, pwrite, setup_rx, store_done, suspend, txn_valid, txn_ok, txn_toggle, stall} = '0;
		{paddr, pwdata, txn_ep, txn_code, txn_pid, last_ep} = '0;
		tog = '{default: 1'h0};
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		for (i = 0; i < 16; i++) begin
			ep = 4'($random(seed));
			lo = 4'({$random(seed)} % 15 + 1);
			r = 2'($random(seed));
			txn(ep, i[3:0], {~lo, lo}, r[0], r[1]);
			order({4'ha, ep}, 8'h0, 8'h0, 2'h0, 1'h1);
			chk(b, est(1'h0, tog[ep], i[3:0], r[0]));
		end
		txn(4'h5, ERR_NAK, 8'hd2, 1'h0, 1'h0);
		txn(4'h5, ERR_STALL, 8'hd2, 1'h0, 1'h0);
		order(8'ha5, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b, est(1'h1, tog[5], ERR_STALL, 1'h0));
		txn(4'h3, ERR_NONE, 8'h00, 1'h0, 1'h0);
		order(8'ha3, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b, est(1'h0, tog[3], ERR_PID_CHECK, 1'h0));
		txn(4'h3, ERR_NONE, 8'hf0, 1'h0, 1'h0);
		order(8'ha3, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b, est(1'h0, tog[3], ERR_PID_UNDEF, 1'h0));
		setup_pkt();
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h0c, 8'h04);
		setup_pkt();
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h08, 8'h08);
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h08, 8'h08);
		store_done <= 1'h1;
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h08, 8'h00);
		s = b;
		chk(setup_cmds_off, 1'h1);
		order(8'h70, 8'h0, 8'h0, 2'h0, 1'h0);
		chk(n_clr, 0);
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h06, s & 8'h06);
		order(CMD_ACK_SETUP, 8'h0, 8'h0, 2'h0, 1'h0);
		order(8'h70, 8'h0, 8'h0, 2'h0, 1'h0);
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h06, {6'h0, ~s[CPU_BUFFER_SELECT_BIT], 1'h0});
		chk(n_clr, 1);
		chk(last_ep, 4'h0);
		order(8'h63, 8'h0, 8'h0, 2'h0, 1'h0);
		chk(n_val, 1);
		chk(last_ep, 4'h3);
		order(8'hd3, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h0e, 8'h02);
		setup_pkt();
		chk(setup_cmds_off, 1'h1);
		stall <= 1'h1;
		@(posedge pclk) stall <= 1'h0;
		@(posedge pclk);
		chk(setup_cmds_off, 1'h0);
		setup_pkt();
		order(8'hd0, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b & 8'h08, 8'h00);
		suspend <= 1'h1;
		@(posedge pclk) suspend <= 1'h0;
		@(posedge pclk);
		chk(write_locked, 1'h1);
		order(8'ha5, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b, 8'h00);
		order(CMD_UNLOCK, 8'h37, 8'h55, 2'h2, 1'h0);
		order(8'ha5, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b, 8'h00);
		order(CMD_UNLOCK, 8'h37, 8'haa, 2'h2, 1'h0);
		chk(write_locked, 1'h0);
		txn(4'h5, ERR_SYNC, 8'hd2, 1'h0, 1'h0);
		order(8'ha5, 8'h0, 8'h0, 2'h0, 1'h1);
		chk(b, est(1'h0, tog[5], ERR_SYNC, 1'h0));
		apb(1'h0, 12'h008, 32'h0);
		chk(e, 1'h1);
		summarize();
	end
endmodule : usb_setup_error_unlock_cmds_test
`default_nettype wire
